// ==== hdl/mbrtu_slave.sv ====
// Purpose: RTU slave front end: link framing, checks, dispatch, inactivity timer
// Assumes: Config, database and access inputs are on clk; rx pin is asynchronous
// Notes:   Database serves data, address and access checks and functions 7/8/11/12
module mbrtu_slave #(
    parameter logic [15:0] DIV_LO  = 16'(mbrtu_pkg::CLK_HZ / mbrtu_pkg::BAUD_LO),
    parameter logic [15:0] DIV_MID = 16'(mbrtu_pkg::CLK_HZ / mbrtu_pkg::BAUD_MID),
    parameter logic [15:0] DIV_HI  = 16'(mbrtu_pkg::CLK_HZ / mbrtu_pkg::BAUD_HI),
    parameter logic [35:0] CYC_MIN = 36'(mbrtu_pkg::CLK_HZ * mbrtu_pkg::MINUTE_S)
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Two-wire link, half duplex
    input  wire logic                     rs485_rx,
    output logic                          rs485_tx,
    output logic                          rs485_tx_oe,
    // Port settings
    input  wire mbrtu_pkg::mbrtu_cfg_t    cfg,
    // Database request and answer
    output logic                          db_req,
    output mbrtu_pkg::mbrtu_db_req_t      db_req_f,
    input  wire logic                     db_done,
    input  wire mbrtu_pkg::mbrtu_db_rsp_t db_rsp,
    input  wire logic                     db_lock,
    // Database access to the frame buffer while serving
    input  wire logic [8:0]               db_mem_rd_idx,
    output logic      [7:0]               db_mem_rdata,
    input  wire logic                     db_mem_wr_en,
    input  wire logic [8:0]               db_mem_wr_idx,
    input  wire logic [7:0]               db_mem_wr_data,
    // Access level and scratchpad activity
    input  wire logic                     acc_default,
    input  wire logic                     pend_any,
    input  wire logic                     pw_raise,
    input  wire logic                     pend_write,
    output logic                          inact_expire
);

    // ************************************************************
    // State
    // ************************************************************
    typedef enum logic [2:0] {
        S_RX, S_CHECK, S_DB, S_TX_RD, S_TX_LD, S_TX_BIT
    } mbrtu_state_t;

    typedef struct packed {
        mbrtu_state_t state;
        logic         rx_s1, rx_s2, rx_prev;
        logic         busy;
        logic [15:0]  cyc;
        logic [3:0]   bitn;
        logic [7:0]   data;
        logic         par_acc;
        logic [5:0]   gap;
        logic [8:0]   len;
        logic         bad;
        logic [15:0]  crc;
        logic [7:0]   hdr_addr;
        mbrtu_pkg::mbrtu_db_req_t req_f;
        logic         req;
        logic [7:0]   exc;
        logic [8:0]   rlen;
        logic [8:0]   tx_idx;
        logic [10:0]  shreg;
        logic         tx_d, tx_oe;
        logic         wr_en;
        logic [8:0]   wr_idx;
        logic [7:0]   wr_data;
        logic         trun;
        logic [4:0]   tmin;
        logic [35:0]  tsub;
        logic         texp;
    } mbrtu_st_t;

    mbrtu_st_t  q, d;
    logic [7:0] mem_rdata;
    logic [8:0] mem_rd_idx;
    logic       mem_wr_en;
    logic [8:0] mem_wr_idx;
    logic [7:0] mem_wr_data;

    if (DIV_HI < 16'h0004 || CYC_MIN == '0) begin : g_chk
        $error("Baud divisor or minute count too small");
    end

    // CRC-16 over one byte, reflected polynomial
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ mbrtu_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [15:0] div;
        logic [7:0]  exc;
        logic [7:0]  b;
        logic [8:0]  body_end;
        logic [4:0]  lim;
        div      = DIV_LO;
        exc      = mbrtu_pkg::EXC_NONE;
        b        = '0;
        body_end = '0;
        lim      = '0;
        d        = q;
        d.rx_s1   = rs485_rx;
        d.rx_s2   = q.rx_s1;
        d.rx_prev = q.rx_s2;
        d.req     = 1'b0;
        d.wr_en   = 1'b0;
        d.texp    = 1'b0;
        // Reserved selection falls back to the slowest rate
        if (cfg.baud_sel == mbrtu_pkg::BAUD_SEL_MID) begin
            div = DIV_MID;
        end else if (cfg.baud_sel == mbrtu_pkg::BAUD_SEL_HI) begin
            div = DIV_HI;
        end
        body_end = (q.exc != mbrtu_pkg::EXC_NONE) ? 9'h003 : mbrtu_pkg::IDX_PAYLOAD + q.rlen;

        case (q.state)
            S_RX: begin
                if (!q.busy) begin
                    if (q.rx_prev && !q.rx_s2) begin
                        d.busy = 1'b1;
                        d.cyc  = div >> 1;
                        d.bitn = '0;
                        d.gap  = '0;
                    end else if (q.len != '0) begin
                        if (q.cyc != '0) begin
                            d.cyc = q.cyc - 16'h0001;
                        end else if (q.gap >= mbrtu_pkg::GAP_BITS) begin
                            // Whole frame seen; verdict decides answer or silence
                            if (!q.bad && q.len >= mbrtu_pkg::FRAME_MIN && q.crc == '0 &&
                                q.hdr_addr == cfg.slave_addr &&
                                cfg.slave_addr >= mbrtu_pkg::ADDR_MIN &&
                                cfg.slave_addr <= mbrtu_pkg::ADDR_MAX) begin
                                d.state = S_CHECK;
                            end
                            d.len = '0;
                            d.bad = 1'b0;
                            d.crc = mbrtu_pkg::CRC_INIT;
                        end else begin
                            d.cyc = div - 16'h0001;
                            d.gap = q.gap + 6'h01;
                        end
                    end
                end else if (q.cyc != '0) begin
                    d.cyc = q.cyc - 16'h0001;
                end else begin
                    d.cyc  = div - 16'h0001;
                    d.bitn = q.bitn + 4'h1;
                    if (q.bitn == 4'h0) begin
                        d.busy = !q.rx_s2; // Glitch shorter than half a bit
                        d.par_acc = 1'b0;
                    end else if (q.bitn <= 4'h8) begin
                        d.data    = {q.rx_s2, q.data[7:1]};
                        d.par_acc = q.par_acc ^ q.rx_s2;
                    end else if (q.bitn == 4'h9) begin
                        if (cfg.parity == mbrtu_pkg::PAR_NONE) begin
                            d.bad = q.bad | !q.rx_s2;
                        end else if ((q.par_acc ^ q.rx_s2) != (cfg.parity == mbrtu_pkg::PAR_ODD)) begin
                            d.bad = 1'b1;
                        end
                    end else begin
                        d.busy = 1'b0;
                        d.gap  = '0;
                        d.bad  = q.bad | !q.rx_s2;
                        if (q.len < 9'(mbrtu_pkg::FRAME_MAX)) begin
                            // Raw binary bytes straight into the buffer
                            d.wr_en   = 1'b1;
                            d.wr_idx  = q.len;
                            d.wr_data = q.data;
                            d.crc     = crc_byte(q.crc, q.data);
                            d.len     = q.len + 9'h001;
                            case (q.len)
                                9'h000: d.hdr_addr = q.data;
                                9'h001: d.req_f.func = q.data;
                                9'h002: d.req_f.start[15:8] = q.data;
                                9'h003: d.req_f.start[7:0] = q.data;
                                9'h004: d.req_f.qty[15:8] = q.data;
                                9'h005: d.req_f.qty[7:0] = q.data;
                                default: ;
                            endcase
                        end else begin
                            d.bad = 1'b1;
                        end
                    end
                end
            end
            S_CHECK: begin
                case (q.req_f.func)
                    mbrtu_pkg::FC_RD_COILS, mbrtu_pkg::FC_RD_INPUTS: begin
                        if (q.req_f.qty == '0 || q.req_f.qty > mbrtu_pkg::QTY_BITS) begin
                            exc = mbrtu_pkg::EXC_VALUE;
                        end
                    end
                    mbrtu_pkg::FC_RD_HOLD, mbrtu_pkg::FC_RD_INREG: begin
                        if (q.req_f.qty == '0 || q.req_f.qty > mbrtu_pkg::QTY_REGS) begin
                            exc = mbrtu_pkg::EXC_VALUE;
                        end
                    end
                    mbrtu_pkg::FC_WR_MANY: begin
                        if (q.req_f.qty == '0 || q.req_f.qty > mbrtu_pkg::QTY_REGS) begin
                            exc = mbrtu_pkg::EXC_VALUE;
                        end else if (db_lock) begin
                            exc = mbrtu_pkg::EXC_BUSY;
                        end
                    end
                    mbrtu_pkg::FC_WR_ONE: begin
                        if (db_lock) begin
                            exc = mbrtu_pkg::EXC_BUSY;
                        end
                    end
                    mbrtu_pkg::FC_RD_STATUS, mbrtu_pkg::FC_DIAG,
                    mbrtu_pkg::FC_EVT_CNT, mbrtu_pkg::FC_EVT_LOG: ;
                    default: exc = mbrtu_pkg::EXC_FUNC;
                endcase
                d.crc    = mbrtu_pkg::CRC_INIT;
                d.tx_idx = '0;
                d.rlen   = '0;
                d.exc    = exc;
                if (exc != mbrtu_pkg::EXC_NONE) begin
                    d.state = S_TX_RD;
                end else begin
                    d.req   = 1'b1;
                    d.state = S_DB;
                end
            end
            S_DB: begin
                if (db_done) begin
                    // Database verdict on address, access and value is passed on
                    exc = db_rsp.exc;
                    if (exc == mbrtu_pkg::EXC_ACK ||
                        (exc == mbrtu_pkg::EXC_NONE && db_rsp.len > mbrtu_pkg::PAYLOAD_MAX)) begin
                        exc = mbrtu_pkg::EXC_FAIL;
                    end
                    d.exc   = exc;
                    d.rlen  = db_rsp.len;
                    d.state = S_TX_RD;
                end
            end
            S_TX_RD: begin
                d.state = S_TX_LD; // Buffer read takes one clock
            end
            S_TX_LD: begin
                if (q.tx_idx == 9'h000) begin
                    b = cfg.slave_addr;
                end else if (q.tx_idx == 9'h001) begin
                    b = q.req_f.func;
                    if (q.exc != mbrtu_pkg::EXC_NONE) begin
                        b = q.req_f.func | mbrtu_pkg::FC_EXC_FLAG;
                    end
                end else if (q.tx_idx == 9'h002 && q.exc != mbrtu_pkg::EXC_NONE) begin
                    b = q.exc;
                end else if (q.tx_idx < body_end) begin
                    b = mem_rdata;
                end else if (q.tx_idx == body_end) begin
                    b = q.crc[7:0];
                end else begin
                    b = q.crc[15:8];
                end
                if (q.tx_idx < body_end) begin
                    d.crc = crc_byte(q.crc, b);
                end
                d.shreg = {1'b1,
                           (cfg.parity == mbrtu_pkg::PAR_NONE) ? 1'b1 :
                           ((^b) ^ (cfg.parity == mbrtu_pkg::PAR_ODD)),
                           b, 1'b0};
                d.tx_d  = 1'b0;
                d.tx_oe = 1'b1;
                d.cyc   = div - 16'h0001;
                d.bitn  = '0;
                d.state = S_TX_BIT;
            end
            default: begin
                if (q.cyc != '0) begin
                    d.cyc = q.cyc - 16'h0001;
                end else if (q.bitn == 4'ha) begin
                    d.tx_idx = q.tx_idx + 9'h001;
                    d.state  = S_TX_RD;
                    if (q.tx_idx == body_end + 9'h001) begin
                        d.tx_oe = 1'b0;
                        d.tx_d  = 1'b1;
                        d.state = S_RX;
                        d.crc   = mbrtu_pkg::CRC_INIT;
                    end
                end else begin
                    d.cyc   = div - 16'h0001;
                    d.bitn  = q.bitn + 4'h1;
                    d.shreg = q.shreg >> 1;
                    d.tx_d  = q.shreg[1];
                end
            end
        endcase

        // Inactivity timer, minutes counted from a per-minute prescaler
        lim = (cfg.inact_min < mbrtu_pkg::INACT_LO) ? mbrtu_pkg::INACT_LO :
              (cfg.inact_min > mbrtu_pkg::INACT_HI) ? mbrtu_pkg::INACT_HI : cfg.inact_min;
        if (pw_raise || pend_write) begin
            d.trun = 1'b1;
            d.tmin = '0;
            d.tsub = '0;
        end else if (acc_default && !pend_any) begin
            d.trun = 1'b0;
            d.tmin = '0;
            d.tsub = '0;
        end else if (q.trun) begin
            if (q.tsub == CYC_MIN - 36'h1) begin
                d.tsub = '0;
                d.tmin = q.tmin + 5'h01;
                if (q.tmin + 5'h01 >= lim) begin
                    d.texp = 1'b1;
                    d.trun = 1'b0;
                end
            end else begin
                d.tsub = q.tsub + 36'h1;
            end
        end

        if (srst) begin
            d        = '0;
            d.state  = S_RX;
            d.rx_s1  = 1'b1;
            d.rx_s2  = 1'b1;
            d.rx_prev = 1'b1;
            d.tx_d   = 1'b1;
            d.crc    = mbrtu_pkg::CRC_INIT;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    // ************************************************************
    // Frame buffer, shared by link and database
    // ************************************************************
    // Database owns the buffer only while serving, so no arbitration is needed
    assign mem_rd_idx  = (q.state == S_DB) ? db_mem_rd_idx : q.tx_idx;
    assign mem_wr_en   = (q.state == S_DB) ? db_mem_wr_en : q.wr_en;
    assign mem_wr_idx  = (q.state == S_DB) ? db_mem_wr_idx : q.wr_idx;
    assign mem_wr_data = (q.state == S_DB) ? db_mem_wr_data : q.wr_data;

    mbrtu_frame_mem #(
        .WIDTH (8),
        .DEPTH (mbrtu_pkg::FRAME_MAX),
        .IW    (9)
    ) u_mem (
        .clk     (clk),
        .srst    (srst),
        .wr_en   (mem_wr_en),
        .wr_idx  (mem_wr_idx),
        .wr_data (mem_wr_data),
        .rd_idx  (mem_rd_idx),
        .rd_data (mem_rdata)
    );

    // Outputs
    assign rs485_tx     = q.tx_d;
    assign rs485_tx_oe  = q.tx_oe;
    assign db_req       = q.req;
    assign db_req_f     = q.req_f;
    assign db_mem_rdata = mem_rdata;
    assign inact_expire = q.texp;

endmodule : mbrtu_slave

// ==== hdl/mbrtu_pkg.sv ====
// Purpose: Shared constants and carrier types for the RTU slave front end
// Assumes: One 200 MHz clock, synchronous active-high reset
// Notes:   Counts above 4096 cycles are top-level parameters fed from here
package mbrtu_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam longint unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned     BAUD_LO     = 9600;
    localparam int unsigned     BAUD_MID    = 19200;
    localparam int unsigned     BAUD_HI     = 38400;
    localparam longint unsigned MINUTE_S    = 60;
    localparam int unsigned     CHAR_BITS   = 11;
    // 3.5 characters of 11 bits is 38.5 bit times, rounded up
    localparam logic [5:0]      GAP_BITS    = 6'h27;

    // ************************************************************
    // Frame layout and limits
    // ************************************************************
    localparam int unsigned FRAME_MAX   = 260;
    localparam logic [8:0]  FRAME_MIN   = 9'h004;
    localparam logic [8:0]  PAYLOAD_MAX = 9'h100;
    localparam logic [8:0]  IDX_PAYLOAD = 9'h002;
    localparam logic [7:0]  ADDR_MIN    = 8'h01;
    localparam logic [7:0]  ADDR_MAX    = 8'hf7;
    localparam logic [15:0] QTY_BITS    = 16'h0020;
    localparam logic [15:0] QTY_REGS    = 16'h007f;
    localparam logic [4:0]  INACT_LO    = 5'h01;
    localparam logic [4:0]  INACT_HI    = 5'h1e;
    localparam logic [15:0] CRC_INIT    = 16'hffff;
    localparam logic [15:0] CRC_POLY    = 16'ha001;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD  = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] BAUD_SEL_LO  = 2'h0;
    localparam logic [1:0] BAUD_SEL_MID = 2'h1;
    localparam logic [1:0] BAUD_SEL_HI  = 2'h2;

    localparam logic [7:0] FC_RD_COILS  = 8'h01;
    localparam logic [7:0] FC_RD_INPUTS = 8'h02;
    localparam logic [7:0] FC_RD_HOLD   = 8'h03;
    localparam logic [7:0] FC_RD_INREG  = 8'h04;
    localparam logic [7:0] FC_WR_ONE    = 8'h06;
    localparam logic [7:0] FC_RD_STATUS = 8'h07;
    localparam logic [7:0] FC_DIAG      = 8'h08;
    localparam logic [7:0] FC_EVT_CNT   = 8'h0b;
    localparam logic [7:0] FC_EVT_LOG   = 8'h0c;
    localparam logic [7:0] FC_WR_MANY   = 8'h10;
    localparam logic [7:0] FC_EXC_FLAG  = 8'h80;

    localparam logic [7:0] EXC_NONE  = 8'h00;
    localparam logic [7:0] EXC_FUNC  = 8'h01;
    localparam logic [7:0] EXC_ADDR  = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FAIL  = 8'h04;
    localparam logic [7:0] EXC_ACK   = 8'h05;
    localparam logic [7:0] EXC_BUSY  = 8'h06;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] baud_sel;
        logic [1:0] parity;
        logic [7:0] slave_addr;
        logic [4:0] inact_min;
    } mbrtu_cfg_t;

    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] start;
        logic [15:0] qty;
    } mbrtu_db_req_t;

    typedef struct packed {
        logic [7:0] exc;
        logic [8:0] len;
    } mbrtu_db_rsp_t;

endpackage : mbrtu_pkg

// ==== hdl/mbrtu_frame_mem.sv ====
// Purpose: Byte buffer holding one frame, registered read data
// Assumes: Writes beyond DEPTH are dropped by the caller or here
// Notes:   Read data appears one clock after the index
module mbrtu_frame_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 260,
    parameter int unsigned IW    = 9
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [IW-1:0]    wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port
    input  wire logic [IW-1:0]    rd_idx,
    output logic      [WIDTH-1:0] rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } mbrtu_mem_st_t;

    mbrtu_mem_st_t q, d;

    if ((1 << IW) < DEPTH) begin : g_chk
        $error("Index width too small for depth");
    end

    // Storage update and registered read
    always_comb begin
        d = q;
        if (wr_en && wr_idx < IW'(DEPTH)) begin
            d.mem[wr_idx] = wr_data;
        end
        d.rdata = (rd_idx < IW'(DEPTH)) ? q.mem[rd_idx] : '0;
        if (srst) begin
            d.rdata = '0; // Contents are data and keep no reset
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign rd_data = q.rdata;

endmodule : mbrtu_frame_mem

// ==== testbench/mbrtu_slave_properties.sv ====
// Purpose: Port checks for the RTU slave
// Assumes: Small divisors and a short minute
// Notes:   Bound to the top module below
module mbrtu_slave_properties (
    // Watched ports
    input wire logic clk, srst, rs485_tx, rs485_tx_oe, db_req, db_done,
    input wire logic acc_default, pend_any, pw_raise, pend_write, inact_expire,
    input wire mbrtu_pkg::mbrtu_db_req_t db_req_f
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Line ownership and dispatch
    property p_idle; !rs485_tx_oe |-> rs485_tx; endproperty
    a_idle: assert property (p_idle) else $error("line low while released");
    property p_quiet; db_req |-> !rs485_tx_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("driving while serving");
    property p_done; db_done |-> ##3 rs485_tx_oe; endproperty
    a_done: assert property (p_done) else $error("no answer after done");
    property p_fc; db_req |-> db_req_f.func inside
        {8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h10}; endproperty
    a_fc: assert property (p_fc) else $error("odd function served");
    property p_qty; db_req && db_req_f.func == 8'h03 |-> db_req_f.qty inside
        {[16'h0001:16'h007f]}; endproperty
    a_qty: assert property (p_qty) else $error("count over limit");
    // Timer: a pulse, never early, silent while stopped
    property p_once; inact_expire |=> !inact_expire; endproperty
    a_once: assert property (p_once) else $error("expiry held");
    property p_early; pw_raise |=> !inact_expire [*8]; endproperty
    a_early: assert property (p_early) else $error("expiry too soon");
    property p_stop; (acc_default && !pend_any && !pw_raise && !pend_write) [*2]
        |=> !inact_expire; endproperty
    a_stop: assert property (p_stop) else $error("expiry while stopped");
    c_req: cover property (db_req);
    c_tx: cover property ($rose(rs485_tx_oe));
    c_exp: cover property (inact_expire);
endmodule : mbrtu_slave_properties
bind mbrtu_slave mbrtu_slave_properties i_props (.clk, .srst, .rs485_tx, .rs485_tx_oe,
    .db_req, .db_done, .acc_default, .pend_any, .pw_raise, .pend_write, .inact_expire,
    .db_req_f);

// ==== testbench/mbrtu_master_model.sv ====
// Purpose: Bus master driving the slave's receive line
// Assumes: Caller starts a frame just after a clock edge
// Notes:   Line rests high between frames, as the biased bus does
module mbrtu_master_model (
    input wire logic clk,
    output logic     rx
);
    initial rx = 1'b1;
    // CRC appended low byte first; bad flips one bit to test dropping
    task automatic send(input logic [7:0] f[$], input int dv, input logic [1:0] par,
                        input logic bad);
        logic [15:0] c;
        logic [10:0] w;
        c = 16'hffff;
        foreach (f[i]) for (int k = 0; k < 8; k++)
            c = {1'b0, c[15:1]} ^ ((c[0] ^ f[i][k]) ? 16'ha001 : 16'h0000);
        f.push_back(c[7:0] ^ {7'h00, bad});
        f.push_back(c[15:8]);
        foreach (f[i]) begin
            w = {1'b1, (par == 2'h0) ? 1'b1 : (^f[i] ^ (par == 2'h1)), f[i], 1'b0};
            for (int b = 0; b < 11; b++) begin
                rx <= w[b];
                repeat (dv) @(posedge clk);
            end
        end
    endtask : send
endmodule : mbrtu_master_model

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the RTU slave
// Assumes: Divisors 16/8/4 and a 20-cycle minute
// Notes:   Bench plays the database; the model plays the master
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, rx, tx, oe, req, done = 0, lock = 0;
    logic acc = 1, pend = 0, pw = 0, pwr = 0, ex, mwe = 0;
    logic [8:0] mri = 9'h003, mwi = 9'h002;
    mbrtu_pkg::mbrtu_cfg_t    cfg = '0;
    mbrtu_pkg::mbrtu_db_req_t rq;
    mbrtu_pkg::mbrtu_db_rsp_t rsp = '0;
    int num_errors = 0, num_checks = 0, cyc = 0, nreq = 0, nexp = 0, n0, dv = 16;
    logic [7:0] b0, b1, b2, mrd, mwd = 8'h5a;
    mbrtu_master_model i_master (.clk(clk), .rx(rx));
    mbrtu_slave #(.DIV_LO(16'h0010), .DIV_MID(16'h0008), .DIV_HI(16'h0004),
        .CYC_MIN(36'h14)) i_dut (.clk(clk), .srst(srst), .rs485_rx(rx), .rs485_tx(tx),
        .rs485_tx_oe(oe), .cfg(cfg), .db_req(req), .db_req_f(rq), .db_done(done),
        .db_rsp(rsp), .db_lock(lock), .db_mem_rd_idx(mri), .db_mem_rdata(mrd),
        .db_mem_wr_en(mwe), .db_mem_wr_idx(mwi), .db_mem_wr_data(mwd),
        .acc_default(acc), .pend_any(pend), .pw_raise(pw), .pend_write(pwr), .inact_expire(ex));
    initial forever #2.5 clk = ~clk;
    // Event counts and a ceiling well past the expected run
    always @(negedge clk) begin
        cyc++;
        nreq += int'(req === 1'b1);
        nexp += int'(ex === 1'b1);
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Three reply bytes sampled mid-bit, then wait out the tail
    task automatic get3();
        for (int n = 0; n < 3; n++) begin
            for (int i = 0; i < 4000 && tx !== 1'b0; i++) @(negedge clk);
            repeat (dv / 2) @(negedge clk);
            {b2, b1} = {b1, b0};
            for (int k = 0; k < 8; k++) begin
                repeat (dv) @(negedge clk);
                b0[k] = tx;
            end
            // Step past parity into the stop bit so a low last bit is not taken as a start
            repeat (2 * dv) @(negedge clk);
        end
        repeat (90 * dv) @(posedge clk);
    endtask : get3
    task automatic t_read(input logic [7:0] e, input logic [23:0] w);
        cfg <= '{2'h0, 2'h2, 8'h11, 5'h01};
        @(posedge clk);
        i_master.send('{8'h11, 8'h03, 8'h00, 8'h07, 8'h00, 8'h02}, 16, 2'h2, 1'b0);
        for (int i = 0; i < 2000 && req !== 1'b1; i++) @(negedge clk);
        chk(rq, {8'h03, 16'h0007, 16'h0002});
        // Database peeks at the start address byte and stages one payload byte
        @(posedge clk) {mwe, rsp} <= {1'b1, e, 9'h001};
        @(negedge clk) chk(mrd, 8'h07);
        @(posedge clk) {mwe, done} <= 2'b01;
        @(posedge clk) done <= 1'b0;
        get3();
        chk({b2, b1, b0}, w);
        $display("read test done");
    endtask : t_read
    task automatic t_exc(input logic [1:0] sel, par, input logic [7:0] fc, e, input logic lk);
        cfg <= '{sel, par, 8'h2a, 5'h01};
        lock <= lk;
        dv = 16 >> sel;
        n0 = nreq;
        @(posedge clk);
        // A count of 129 is over both limits, so only counted functions object
        i_master.send('{8'h2a, fc, 8'h00, 8'h00, 8'h00, 8'h81}, dv, par, 1'b0);
        get3();
        chk({b2, b1, b0, 8'(nreq - n0)}, {8'h2a, fc | 8'h80, e, 8'h00});
        $display("exception test done");
    endtask : t_exc
    task automatic t_drop(input logic [7:0] a, input logic bad);
        logic seen;
        seen = 1'b0;
        n0 = nreq;
        @(posedge clk);
        i_master.send('{a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, dv, cfg.parity, bad);
        repeat (1000) begin
            @(negedge clk);
            seen |= oe;
        end
        chk({seen, 8'(nreq - n0)}, 40'h0);
        $display("drop test done");
    endtask : t_drop
    task automatic t_timer();
        int t;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {acc, pend, pw, pwr} <= {k[0], k[0], !k[0], k[0]};
            @(posedge clk);
            {pw, pwr} <= 2'b00;
            for (t = 0; t < 200 && ex !== 1'b1; t++) @(negedge clk);
            chk(t inside {[18:30]}, 1);
        end
        // Restart, then fall back to the stopped condition well inside a minute
        @(posedge clk) pwr <= 1'b1;
        @(posedge clk) {pend, pwr} <= 2'b00;
        n0 = nexp;
        repeat (200) @(posedge clk);
        chk(nexp - n0, 0);
        $display("timer test done");
    endtask : t_timer
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        t_read(8'h02, 24'h118302);
        t_read(8'h00, 24'h11035a);
        t_exc(2'h1, 2'h1, 8'h05, 8'h01, 1'b0);
        t_exc(2'h2, 2'h0, 8'h06, 8'h06, 1'b1);
        t_exc(2'h0, 2'h1, 8'h10, 8'h03, 1'b0);
        t_drop(8'h2b, 1'b0);
        t_drop(8'h2a, 1'b1);
        t_timer();
        results();
    end
endmodule : tb_top
